// ==== verilog/display_record_serial_sender.sv ====
// Display record framer and 8N1 serial sender with display recognition.
//
// Behaviour
// - Strap selects recognition or fixed-record mode.
// - Recognition mode detects display type by itself.
// - 2400 baud, 8N1, no handshake.
// - Record is 97 bytes in fixed field order.
// - Total energy: six decimal ASCII digits.
// - Daily energy: four decimal ASCII digits.
// - Output: four digits, implied decimal point.
// - Irradiance: four decimal ASCII digits.
// - Sixteen spaces follow the output field.
// - Two ASCII zeros before and two after irradiance field.
// - Fifty-six spaces, then CR and LF.
// - Leading zeros are always sent.
// - Irradiance only from sensor address one.
// - Missing sensor gives irradiance zero.
module display_record_serial_sender #(
  parameter int unsigned BIT_CYCLES = display_record_pkg::BIT_CYCLES,
  parameter int unsigned REC_GAP_CYCLES = display_record_pkg::REC_GAP_CYCLES,
  parameter int unsigned LISTEN_CYCLES = display_record_pkg::LISTEN_CYCLES
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic mode_auto_in,
  input wire logic vals_load_in,
  input wire display_record_pkg::record_vals_s vals_in,
  input wire logic irr_strobe_in,
  input wire logic [3:0] irr_addr_in,
  input wire logic [13:0] irr_value_in,
  input wire logic irr_sensor_ok_in,
  input wire logic rxd_in,
  output logic txd_out,
  output logic busy_out,
  output logic detected_out,
  output logic [7:0] disp_type_out
);
  // Counters are 32 bits wide, so tiny bit times and zero gap or listen times are the only limits.
  if (BIT_CYCLES < 4 || REC_GAP_CYCLES < 1 || LISTEN_CYCLES < 1) begin : g_chk
    $error("display_record_serial_sender: timing parameters too small");
  end

  typedef enum logic [6:0] {
    ST_IDLE = 7'b000_0001,
    ST_LOAD = 7'b000_0010,
    ST_START = 7'b000_0100,
    ST_DATA = 7'b000_1000,
    ST_STOP = 7'b001_0000,
    ST_LISTEN = 7'b010_0000,
    ST_GAP = 7'b100_0000
  } tx_state_e;

  // Decimal digit of val at position pos (0 is the units digit).
  function automatic logic [7:0] dec_digit(input logic [31:0] val,
                                           input logic [6:0] pos);
    logic [31:0] v;
    v = val;
    for (int k = 0; k < 6; k++) begin
      if (7'(k) < pos) begin
        v = v / 32'h0000_000a;
      end
    end
    return display_record_pkg::CH_ZERO + 8'(v % 32'h0000_000a);
  endfunction

  // Byte at record index i for the frozen values v.
  function automatic logic [7:0] rec_byte(input logic [6:0] i,
      input display_record_pkg::record_vals_s v);
    logic [7:0] b;
    b = display_record_pkg::CH_SPACE;
    if (i == display_record_pkg::IDX_HASH) begin
      b = display_record_pkg::CH_HASH;
    end else if (i < display_record_pkg::IDX_DAILY) begin
      b = dec_digit(32'(v.total_kwh),
                    display_record_pkg::IDX_DAILY - 7'h01 - i);
    end else if (i < display_record_pkg::IDX_POWER) begin
      b = dec_digit(32'(v.daily_kwh),
                    display_record_pkg::IDX_POWER - 7'h01 - i);
    end else if (i < display_record_pkg::IDX_PAD1) begin
      b = dec_digit(32'(v.power_ckw),
                    display_record_pkg::IDX_PAD1 - 7'h01 - i);
    end else if (i < display_record_pkg::IDX_ZERO1) begin
      b = display_record_pkg::CH_SPACE;
    end else if (i < display_record_pkg::IDX_IRR) begin
      b = display_record_pkg::CH_ZERO;
    end else if (i < display_record_pkg::IDX_ZERO2) begin
      b = dec_digit(32'(v.irr_wm2),
                    display_record_pkg::IDX_ZERO2 - 7'h01 - i);
    end else if (i < display_record_pkg::IDX_PAD2) begin
      b = display_record_pkg::CH_ZERO;
    end else if (i < display_record_pkg::IDX_CR) begin
      b = display_record_pkg::CH_SPACE;
    end else if (i == display_record_pkg::IDX_CR) begin
      b = display_record_pkg::CH_CR;
    end else begin
      b = display_record_pkg::CH_LF;
    end
    return b;
  endfunction

  // Pin synchronisers: stage one is read only by stage two.
  logic mode_m_q, mode_s_q, rx_m_q, rx_s_q;
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_m_q <= 1'b0;
      mode_s_q <= 1'b0;
      rx_m_q <= 1'b1;
      rx_s_q <= 1'b1;
    end else begin
      mode_m_q <= mode_auto_in;
      mode_s_q <= mode_m_q;
      rx_m_q <= rxd_in;
      rx_s_q <= rx_m_q;
    end
  end

  // Live value store; irradiance is fed by one sensor address only.
  display_record_pkg::record_vals_s vals_q, vals_d;
  always_comb begin
    vals_d = vals_q;
    if (vals_load_in) begin
      vals_d.total_kwh = vals_in.total_kwh;
      vals_d.daily_kwh = vals_in.daily_kwh;
      vals_d.power_ckw = vals_in.power_ckw;
    end
    if (!irr_sensor_ok_in) begin
      vals_d.irr_wm2 = 14'h0000;
    end else if (irr_strobe_in &&
                 irr_addr_in == display_record_pkg::IRR_SENSOR_ADDR) begin
      vals_d.irr_wm2 = irr_value_in;
    end
  end
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      vals_q <= '0;
    end else begin
      vals_q <= vals_d;
    end
  end

  // Answer receiver, armed only while waiting for a display reply.
  logic rx_busy_q, rx_busy_d, rx_done_q, rx_done_d;
  logic [31:0] rx_cnt_q, rx_cnt_d;
  logic [3:0] rx_bit_q, rx_bit_d;
  logic [7:0] rx_sh_q, rx_sh_d;
  tx_state_e state_q, state_d;
  always_comb begin
    rx_busy_d = rx_busy_q;
    rx_cnt_d = rx_cnt_q;
    rx_bit_d = rx_bit_q;
    rx_sh_d = rx_sh_q;
    rx_done_d = 1'b0;
    if (state_q != ST_LISTEN) begin
      rx_busy_d = 1'b0;
    end else if (!rx_busy_q) begin
      if (!rx_s_q) begin
        // Sample each bit in its middle.
        rx_busy_d = 1'b1;
        rx_cnt_d = 32'(BIT_CYCLES / 2);
        rx_bit_d = 4'h0;
      end
    end else if (rx_cnt_q != 32'h0) begin
      rx_cnt_d = rx_cnt_q - 32'h1;
    end else begin
      rx_cnt_d = 32'(BIT_CYCLES - 1);
      rx_bit_d = rx_bit_q + 4'h1;
      if (rx_bit_q == 4'h0) begin
        rx_busy_d = ~rx_s_q; // A glitch, not a start bit.
      end else if (rx_bit_q <= 4'(display_record_pkg::DATA_BITS)) begin
        rx_sh_d = {rx_s_q, rx_sh_q[7:1]};
      end else begin
        rx_busy_d = 1'b0;
        rx_done_d = rx_s_q;
      end
    end
  end
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_busy_q <= 1'b0;
      rx_cnt_q <= 32'h0;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 8'h00;
      rx_done_q <= 1'b0;
    end else begin
      rx_busy_q <= rx_busy_d;
      rx_cnt_q <= rx_cnt_d;
      rx_bit_q <= rx_bit_d;
      rx_sh_q <= rx_sh_d;
      rx_done_q <= rx_done_d;
    end
  end

  // Transmit sequencer. The mode strap is looked at only between records,
  // so a strap change can never cut a frame short.
  logic [31:0] cnt_q, cnt_d;
  logic [2:0] bit_q, bit_d;
  logic [6:0] idx_q, idx_d;
  logic [7:0] byte_q, byte_d, type_q, type_d;
  logic probe_q, probe_d, det_q, det_d, tx_q, tx_d;
  display_record_pkg::record_vals_s snap_q, snap_d;
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    bit_d = bit_q;
    idx_d = idx_q;
    byte_d = byte_q;
    type_d = type_q;
    probe_d = probe_q;
    det_d = det_q;
    snap_d = snap_q;
    tx_d = 1'b1;
    unique case (state_q)
      ST_IDLE: begin
        state_d = ST_LOAD;
        idx_d = display_record_pkg::IDX_HASH;
        snap_d = vals_q;
        if (!mode_s_q) begin
          det_d = 1'b0;
          probe_d = 1'b0;
        end else begin
          probe_d = ~det_q;
        end
      end
      ST_LOAD: begin
        byte_d = probe_q ? display_record_pkg::CH_QUERY
                         : rec_byte(idx_q, snap_q);
        cnt_d = 32'(BIT_CYCLES - 1);
        state_d = ST_START;
      end
      ST_START: begin
        tx_d = 1'b0;
        if (cnt_q != 32'h0) begin
          cnt_d = cnt_q - 32'h1;
        end else begin
          cnt_d = 32'(BIT_CYCLES - 1);
          bit_d = 3'h0;
          state_d = ST_DATA;
          tx_d = byte_q[0];
        end
      end
      ST_DATA: begin
        tx_d = byte_q[bit_q];
        if (cnt_q != 32'h0) begin
          cnt_d = cnt_q - 32'h1;
        end else begin
          cnt_d = 32'(BIT_CYCLES - 1);
          bit_d = bit_q + 3'h1;
          if (bit_q == 3'(display_record_pkg::DATA_BITS - 1)) begin
            state_d = ST_STOP;
            tx_d = 1'b1;
          end else begin
            tx_d = byte_q[bit_q + 3'h1];
          end
        end
      end
      ST_STOP: begin
        if (cnt_q != 32'h0) begin
          cnt_d = cnt_q - 32'h1;
        end else if (probe_q) begin
          cnt_d = 32'(LISTEN_CYCLES - 1);
          state_d = ST_LISTEN;
        end else if (idx_q == display_record_pkg::IDX_LF) begin
          cnt_d = 32'(REC_GAP_CYCLES - 1);
          state_d = ST_GAP;
        end else begin
          idx_d = idx_q + 7'h01;
          state_d = ST_LOAD;
        end
      end
      ST_LISTEN: begin
        if (rx_done_q) begin
          type_d = rx_sh_q;
          det_d = 1'b1;
          state_d = ST_IDLE;
        end else if (cnt_q != 32'h0) begin
          cnt_d = cnt_q - 32'h1;
        end else if (!rx_busy_q) begin
          cnt_d = 32'(REC_GAP_CYCLES - 1);
          state_d = ST_GAP;
        end
      end
      ST_GAP: begin
        if (cnt_q != 32'h0) begin
          cnt_d = cnt_q - 32'h1;
        end else begin
          state_d = ST_IDLE;
        end
      end
    endcase
  end
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= ST_IDLE;
      cnt_q <= 32'h0;
      bit_q <= 3'h0;
      idx_q <= 7'h00;
      byte_q <= 8'h00;
      type_q <= 8'h00;
      probe_q <= 1'b0;
      det_q <= 1'b0;
      snap_q <= '0;
      tx_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      bit_q <= bit_d;
      idx_q <= idx_d;
      byte_q <= byte_d;
      type_q <= type_d;
      probe_q <= probe_d;
      det_q <= det_d;
      snap_q <= snap_d;
      tx_q <= tx_d;
    end
  end

  // Status flops feeding the outputs.
  logic busy_q;
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= !(state_d inside {ST_IDLE, ST_GAP});
    end
  end
  assign txd_out = tx_q;
  assign busy_out = busy_q;
  assign detected_out = det_q;
  assign disp_type_out = type_q;

  // Checks kept next to the sequencer.
  a_idle_line_high:
  assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    state_q == ST_GAP |=> txd_out) else $error("line not idle in gap");
  a_start_bit_len:
  assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $rose(state_q == ST_START) |=> !txd_out [*4])
    else $error("start bit too short");
  a_stop_bit_high:
  assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    state_q == ST_STOP && $past(state_q) == ST_STOP |-> txd_out)
    else $error("stop bit not high");
  a_record_opens_hash:
  assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    state_q == ST_LOAD && !probe_q && idx_q == display_record_pkg::IDX_HASH
    |=> byte_q == display_record_pkg::CH_HASH) else $error("no start char");
  a_pad_is_space:
  assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    state_q == ST_LOAD && !probe_q && idx_q >= display_record_pkg::IDX_PAD1
    && idx_q < display_record_pkg::IDX_ZERO1
    |=> byte_q == display_record_pkg::CH_SPACE) else $error("bad pad byte");
  a_zero_pairs:
  assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    state_q == ST_LOAD && !probe_q &&
    (idx_q inside {[display_record_pkg::IDX_ZERO1 :
                    display_record_pkg::IDX_IRR - 7'h01],
                   [display_record_pkg::IDX_ZERO2 :
                    display_record_pkg::IDX_PAD2 - 7'h01]})
    |=> byte_q == display_record_pkg::CH_ZERO) else $error("bad zero pair");
  a_record_tail:
  assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    state_q == ST_LOAD && !probe_q && idx_q == display_record_pkg::IDX_LF
    |=> byte_q == display_record_pkg::CH_LF &&
    $past(idx_q) == display_record_pkg::IDX_LF)
    else $error("bad record end");
  a_digits_ascii:
  assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    state_q == ST_LOAD && !probe_q && idx_q >= display_record_pkg::IDX_TOTAL
    && idx_q < display_record_pkg::IDX_PAD1
    |=> byte_q inside {[8'h30 : 8'h39]}) else $error("digit not ascii");
  a_irr_source:
  assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $changed(vals_q.irr_wm2) |-> vals_q.irr_wm2 == 14'h0000 ||
    $past(irr_addr_in) == display_record_pkg::IRR_SENSOR_ADDR)
    else $error("irradiance from wrong unit");
  a_irr_missing:
  assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    !irr_sensor_ok_in |=> vals_q.irr_wm2 == 14'h0000)
    else $error("irradiance not zeroed");
  a_whole_records:
  assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    state_q == ST_IDLE && !mode_s_q |=> idx_q == 7'h00 && !probe_q)
    else $error("record not started from its first byte");
endmodule

// ==== verilog/display_record_pkg.sv ====
// Constants, types and record layout for the display record serial sender.
package display_record_pkg;
  // Link timing.
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned BAUD = 2400;
  localparam int unsigned BIT_CYCLES = (CLK_HZ + BAUD / 2) / BAUD;
  localparam int unsigned DATA_BITS = 8;
  // Pause between records and wait for a display answer, in milliseconds.
  localparam int unsigned REC_GAP_MS = 1000;
  localparam int unsigned LISTEN_MS = 100;
  localparam int unsigned REC_GAP_CYCLES = CLK_HZ / 1000 * REC_GAP_MS;
  localparam int unsigned LISTEN_CYCLES = CLK_HZ / 1000 * LISTEN_MS;

  // Record layout as byte indices.
  localparam int unsigned TOTAL_DIGITS = 6;
  localparam int unsigned DAILY_DIGITS = 4;
  localparam int unsigned POWER_DIGITS = 4;
  localparam int unsigned IRR_DIGITS = 4;
  localparam int unsigned PAD1_LEN = 16;
  localparam int unsigned ZERO_LEN = 2;
  localparam int unsigned PAD2_LEN = 56;
  localparam logic [6:0] IDX_HASH = 7'h00;
  localparam logic [6:0] IDX_TOTAL = IDX_HASH + 7'h01;
  localparam logic [6:0] IDX_DAILY = IDX_TOTAL + 7'(TOTAL_DIGITS);
  localparam logic [6:0] IDX_POWER = IDX_DAILY + 7'(DAILY_DIGITS);
  localparam logic [6:0] IDX_PAD1 = IDX_POWER + 7'(POWER_DIGITS);
  localparam logic [6:0] IDX_ZERO1 = IDX_PAD1 + 7'(PAD1_LEN);
  localparam logic [6:0] IDX_IRR = IDX_ZERO1 + 7'(ZERO_LEN);
  localparam logic [6:0] IDX_ZERO2 = IDX_IRR + 7'(IRR_DIGITS);
  localparam logic [6:0] IDX_PAD2 = IDX_ZERO2 + 7'(ZERO_LEN);
  localparam logic [6:0] IDX_CR = IDX_PAD2 + 7'(PAD2_LEN);
  localparam logic [6:0] IDX_LF = IDX_CR + 7'h01;
  localparam int unsigned REC_LEN = 97;

  // Character codes.
  localparam logic [7:0] CH_HASH = 8'h23;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  // Query sent in recognition mode; the value is arbitrary.
  localparam logic [7:0] CH_QUERY = 8'h3f;
  // Network address of the only sensor unit allowed to feed irradiance.
  localparam logic [3:0] IRR_SENSOR_ADDR = 4'h1;

  // Values carried into a record.
  typedef struct packed {
    logic [19:0] total_kwh;
    logic [13:0] daily_kwh;
    logic [13:0] power_ckw;
    logic [13:0] irr_wm2;
  } record_vals_s;
endpackage

// ==== tb/display_model.sv ====
// Behavioural model of the large display on the far end of the serial line.
module display_model #(
  parameter int BIT_CYCLES = 8
) (
  input wire logic clk_in,
  input wire logic txd_in,
  output logic rxd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx_q[$];
  int frame_errs;
  bit answer_en;
  logic [7:0] answer_byte;

  // The answer line idles at mark, as an idle serial line must.
  initial begin
    rxd_out = 1'b1;
    frame_errs = 0;
    answer_en = 1'b0;
    answer_byte = 8'h00;
  end

  // Sends one 8N1 byte, each bit held for a full bit time after an edge.
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_in);
      rxd_out <= frame[i];
      repeat (BIT_CYCLES - 1) @(posedge clk_in);
    end
  endtask

  // Samples each bit at its middle; a bad start or stop bit is counted.
  always begin : rx_proc
    logic [7:0] b;
    @(negedge txd_in);
    repeat (BIT_CYCLES / 2) @(posedge clk_in);
    if (txd_in !== 1'b0) frame_errs++;
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYCLES) @(posedge clk_in);
      b[i] = txd_in;
    end
    repeat (BIT_CYCLES) @(posedge clk_in);
    if (txd_in !== 1'b1) frame_errs++;
    rx_q.push_back(b);
    // Only a display told to answer replies, and only after the stop bit.
    if (answer_en && b === 8'h3f) begin
      repeat (BIT_CYCLES) @(posedge clk_in);
      send_byte(answer_byte);
    end
  end
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the display record serial sender.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BC = 6;
  logic ref_clk_in, rst_n_in, mode_auto_in, vals_load_in, irr_strobe_in;
  logic irr_sensor_ok_in, rxd_in, txd_out, busy_out, detected_out;
  logic [3:0] irr_addr_in;
  logic [13:0] irr_value_in;
  logic [7:0] disp_type_out;
  display_record_pkg::record_vals_s vals_in, last_v;
  int num_errors, tests_run, last_irr;
  logic [31:0] rng;
  logic [7:0] exp_q[$];

  display_record_serial_sender #(
    .BIT_CYCLES(BC), .REC_GAP_CYCLES(20), .LISTEN_CYCLES(200)
  ) display_record_serial_sender_inst (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .mode_auto_in(mode_auto_in), .vals_load_in(vals_load_in),
    .vals_in(vals_in), .irr_strobe_in(irr_strobe_in),
    .irr_addr_in(irr_addr_in), .irr_value_in(irr_value_in),
    .irr_sensor_ok_in(irr_sensor_ok_in), .rxd_in(rxd_in),
    .txd_out(txd_out), .busy_out(busy_out),
    .detected_out(detected_out), .disp_type_out(disp_type_out)
  );

  display_model #(.BIT_CYCLES(BC)) display_model_inst (
    .clk_in(ref_clk_in), .txd_in(txd_out), .rxd_out(rxd_in)
  );

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  // One decimal digit as ASCII; values wider than the field wrap.
  function automatic logic [7:0] dig(input int v, input int p);
    return 8'h30 + 8'((v / (10 ** p)) % 10);
  endfunction

  // Builds the expected 97-byte record from the field layout.
  function automatic void build(input display_record_pkg::record_vals_s v,
                                input int irr);
    exp_q = {};
    exp_q.push_back(8'h23);
    for (int p = 5; p >= 0; p--) exp_q.push_back(dig(int'(v.total_kwh), p));
    for (int p = 3; p >= 0; p--) exp_q.push_back(dig(int'(v.daily_kwh), p));
    for (int p = 3; p >= 0; p--) exp_q.push_back(dig(int'(v.power_ckw), p));
    repeat (16) exp_q.push_back(8'h20);
    repeat (2) exp_q.push_back(8'h30);
    for (int p = 3; p >= 0; p--) exp_q.push_back(dig(irr, p));
    repeat (2) exp_q.push_back(8'h30);
    repeat (56) exp_q.push_back(8'h20);
    exp_q.push_back(8'h0d);
    exp_q.push_back(8'h0a);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] expd);
    tests_run++;
    if (seen !== expd) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, expd);
    end
  endtask

  task automatic report_and_stop;
    $display("mismatches %0d of %0d checks", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Waits for an idle span longer than any gap between bytes, then for
  // the next record or probe to start.
  task automatic wait_gap;
    int n, k;
    n = 0;
    k = 0;
    while (n < 12 && k < 20000) begin
      @(posedge ref_clk_in);
      k++;
      n = (busy_out === 1'b0) ? n + 1 : 0;
    end
    while (busy_out !== 1'b1 && k < 20000) begin
      @(posedge ref_clk_in);
      k++;
    end
    if (k >= 20000) check(32'h1, 32'h0);
    @(negedge ref_clk_in);
  endtask

  task automatic collect(input int n);
    int k;
    k = 0;
    while (display_model_inst.rx_q.size() < n && k < 20000) begin
      @(posedge ref_clk_in);
      k++;
    end
    if (k >= 20000) check(32'h2, 32'h0);
  endtask

  task automatic check_record;
    for (int i = 0; i < 97; i++) begin
      check(display_model_inst.rx_q[i], exp_q[i]);
    end
  endtask

  // Applies inputs mid-record; the record after the next gap must use them.
  task automatic run_case(input display_record_pkg::record_vals_s v,
                          input int irr, input logic [3:0] a,
                          input logic ok, input int exp_irr);
    @(negedge ref_clk_in);
    vals_in = v;
    irr_value_in = 14'(irr);
    irr_addr_in = a;
    irr_sensor_ok_in = ok;
    // One-cycle load and strobe: the store must hold the values after.
    vals_load_in = 1'b1;
    irr_strobe_in = 1'b1;
    @(negedge ref_clk_in);
    vals_load_in = 1'b0;
    irr_strobe_in = 1'b0;
    wait_gap();
    display_model_inst.rx_q = {};
    collect(97);
    build(v, exp_irr);
    check_record();
    wait_gap();
    check(32'(display_model_inst.rx_q.size()), 32'd97);
    last_v = v;
    last_irr = exp_irr;
  endtask

  initial begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end

  // Guards against a hang; the span is well above the expected run.
  initial begin
    repeat (100000) @(posedge ref_clk_in);
    num_errors++;
    report_and_stop();
  end

  initial begin
    display_record_pkg::record_vals_s v;
    num_errors = 0;
    tests_run = 0;
    rng = 32'h7b08;
    rst_n_in = 1'b0;
    mode_auto_in = 1'b0;
    vals_load_in = 1'b1;
    irr_strobe_in = 1'b1;
    irr_addr_in = 4'h1;
    irr_value_in = 14'h0000;
    irr_sensor_ok_in = 1'b1;
    vals_in = '0;
    repeat (20) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    check(32'(txd_out), 32'h1);
    check(32'(busy_out), 32'h0);
    rst_n_in = 1'b1;
    // Random in-range values first.
    rng = xorshift(rng);
    v.total_kwh = 20'(rng % 1000000);
    rng = xorshift(rng);
    v.daily_kwh = 14'(rng % 10000);
    v.power_ckw = 14'(rng[31:16] % 10000);
    v.irr_wm2 = rng[13:0];
    rng = xorshift(rng);
    run_case(v, int'(rng % 10000), 4'h1, 1'b1, int'(rng % 10000));
    // All zeros keep their leading zeros; a missing sensor reads zero.
    run_case('0, 7, 4'h1, 1'b0, 0);
    // Widest values wrap to their low digits.
    v = '1;
    run_case(v, 9999, 4'h1, 1'b1, 9999);
    // A strobe from another sensor address leaves irradiance untouched.
    run_case(v, 1234, 4'h2, 1'b1, 9999);
    // Recognition mode with a silent display keeps probing.
    @(negedge ref_clk_in);
    mode_auto_in = 1'b1;
    wait_gap();
    display_model_inst.rx_q = {};
    collect(2);
    check(display_model_inst.rx_q[0], 8'h3f);
    check(display_model_inst.rx_q[1], 8'h3f);
    check(32'(detected_out), 32'h0);
    rng = xorshift(rng);
    display_model_inst.answer_byte = rng[7:0];
    display_model_inst.answer_en = 1'b1;
    for (int k = 0; k < 2000 && detected_out !== 1'b1; k++) begin
      @(posedge ref_clk_in);
    end
    display_model_inst.rx_q = {};
    @(negedge ref_clk_in);
    check(32'(detected_out), 32'h1);
    check(32'(disp_type_out), 32'(rng[7:0]));
    collect(97);
    build(last_v, last_irr);
    check_record();
    // Back to fixed mode at the next record boundary.
    @(negedge ref_clk_in);
    mode_auto_in = 1'b0;
    display_model_inst.answer_en = 1'b0;
    wait_gap();
    display_model_inst.rx_q = {};
    check(32'(detected_out), 32'h0);
    collect(1);
    check(display_model_inst.rx_q[0], 8'h23);
    check(32'(display_model_inst.frame_errs), 32'h0);
    report_and_stop();
  end
endmodule
